// [dv/bsp_stage_model.sv]
// power stage stand-in: inductor ramp, peak flag and timer capacitor
`timescale 1ns/1ps
`default_nettype none
module bsp_stage_model #(
  parameter int TIMER_TOP = 400
) (
  input wire logic clock_in,
  input wire logic boost_gate_in,
  input wire logic timer_clear_in,
  input wire logic regular_operation_en_in,
  input wire logic dimming_pwm_in,
  input wire logic [9:0] peak_level_in,
  output logic peak_current_out,
  output logic timer_at_zero_out,
  output logic timer_expired_out
);
  logic [9:0] ramp_q;
  logic [9:0] timer_q;
  // stuck-low timing charges nine times faster than the retry delay
  always_ff @(posedge clock_in) begin
    ramp_q <= boost_gate_in ? ramp_q + 10'h1 : 10'h0;
    if (timer_clear_in)
      timer_q <= 10'h0;
    else if (timer_q < 10'(TIMER_TOP))
      timer_q <= timer_q + ((regular_operation_en_in && !dimming_pwm_in) ? 10'h9 : 10'h1);
  end
  assign peak_current_out = boost_gate_in && ramp_q >= peak_level_in;
  assign timer_at_zero_out = timer_q < 10'h4;
  assign timer_expired_out = timer_q >= 10'(TIMER_TOP);
endmodule : bsp_stage_model
`default_nettype wire

// [dv/bsp_top_assertions.sv]
// port assertions for the boost pulse and fault logic
`timescale 1ns/1ps
`default_nettype none
module bsp_top_assertions (
  input wire logic clock_in, rst_in, psel_in, penable_in, pready_out,
  input wire logic dimming_pwm_in, peak_current_in, output_over_voltage_in,
  input wire logic input_supply_low_in, boost_gate_out, load_gate_out,
  input wire logic regular_operation_en_out, timer_clear_out, flyback_off_out
);
  logic [9:0] on_q, per_q;
  logic per_ok_q;
  // period only judged across cycles not cut by a dimming restart
  always_ff @(posedge clock_in) begin
    on_q <= boost_gate_out ? on_q + 10'h1 : 10'h0;
    per_q <= $rose(boost_gate_out) ? 10'h0 : per_q + 10'h1;
    per_ok_q <= !rst_in && dimming_pwm_in && regular_operation_en_out
                && (per_ok_q || $rose(boost_gate_out));
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_dim_rise;
    $rose(dimming_pwm_in) && regular_operation_en_out ##1 dimming_pwm_in [*4];
  endsequence
  a_duty_cap: assert property ($rose(boost_gate_out) |-> ##[1:312] !boost_gate_out)
    else $error("gate pulse beyond half period");
  a_period_fixed: assert property ($rose(boost_gate_out) && per_ok_q |-> per_q == 10'h270)
    else $error("switching period wrong");
  a_peak_ends: assert property (peak_current_in [*4] ##0 on_q > 10'h10 |-> !boost_gate_out)
    else $error("peak flag did not end pulse");
  a_blank_hold: assert property (disable iff (rst_in || !dimming_pwm_in || !regular_operation_en_out)
    $rose(boost_gate_out) |-> boost_gate_out [*8]) else $error("pulse cut inside blanking");
  a_dim_off: assert property (!dimming_pwm_in [*4] |-> !boost_gate_out && !load_gate_out)
    else $error("gates on while dimming low");
  a_dim_restart: assert property (s_dim_rise |-> boost_gate_out)
    else $error("no fresh cycle on dimming rise");
  a_gates_in_run: assert property (!regular_operation_en_out [*2] |-> !boost_gate_out && !load_gate_out)
    else $error("gate on outside regular operation");
  a_ov_flyback: assert property (output_over_voltage_in [*4] |-> flyback_off_out)
    else $error("flyback not forced off");
  a_supply_stop: assert property (input_supply_low_in [*6] |-> !regular_operation_en_out)
    else $error("running with supply low");
  a_reset_safe: assert property (disable iff (1'b0) rst_in |=> !boost_gate_out && !load_gate_out && timer_clear_out)
    else $error("outputs not safe after reset");
  a_apb_ready: assert property (psel_in && penable_in |-> pready_out)
    else $error("no ready in access phase");
endmodule : bsp_top_assertions
bind bsp_top bsp_top_assertions chk_u (.*);
`default_nettype wire

// [dv/bsp_top_tb.sv]
// self-checking bench for the boost pulse and fault logic
`timescale 1ns/1ps
`default_nettype none
module bsp_top_tb;
  logic clock_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, err;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, logic_supply_low_in = 0, input_supply_low_in = 1;
  logic headroom_low_in = 0, output_over_voltage_in = 0, load_over_current_in = 0;
  logic dimming_pwm_in = 1, timer_at_zero_in, timer_expired_in, peak_current_in;
  logic boost_gate_out, load_gate_out, regular_operation_en_out, timer_clear_out, flyback_off_out;
  logic [9:0] pk_lvl = 10'h3ff;
  int num_errors = 0, cmp_count = 0, n, h, p;
  wire run = regular_operation_en_out;
  initial forever #4 clock_in = ~clock_in;
  bsp_top dut_u (.*);
  bsp_stage_model stage_u (.clock_in, .boost_gate_in(boost_gate_out),
    .timer_clear_in(timer_clear_out), .regular_operation_en_in(run), .dimming_pwm_in,
    .peak_level_in(pk_lvl), .peak_current_out(peak_current_in),
    .timer_at_zero_out(timer_at_zero_in), .timer_expired_out(timer_expired_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : chk1
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_in);
  endtask : cyc
  task automatic wait_run(input logic v);
    for (n = 0; n < 2000 && run !== v; n++) cyc(1);
    chk1(run, v);
  endtask : wait_run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    cyc(1);
    penable_in <= 1'b1;
    do cyc(1); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    cyc(1);
  endtask : apb
  task automatic measure(input logic [9:0] lvl);
    pk_lvl <= lvl;
    for (n = 0; n < 700 && boost_gate_out !== 1'b0; n++) cyc(1);
    for (n = 0; n < 700 && boost_gate_out !== 1'b1; n++) cyc(1);
    for (h = 0; h < 700 && boost_gate_out === 1'b1; h++) cyc(1);
    for (p = h; p < 1400 && boost_gate_out !== 1'b1; p++) cyc(1);
  endtask : measure
  task automatic t_start;
    cyc(20);
    chk1(run, 1'b0);
    chk1(timer_clear_out, 1'b1);
    input_supply_low_in <= 1'b0;
    wait_run(1'b1);
  endtask : t_start
  task automatic t_pwm;
    measure(10'h3ff);
    chk(h, 312);
    chk(p, 625);
    measure(10'h28);
    chk1(h > 40 && h < 312, 1'b1);
    chk(p, 625);
    measure(10'h0);
    chk1(h >= 10 && h < 14, 1'b1);
    pk_lvl <= 10'h3ff;
  endtask : t_pwm
  task automatic t_dim;
    dimming_pwm_in <= 1'b0;
    cyc(15);
    chk1(boost_gate_out | load_gate_out, 1'b0);
    chk1(timer_clear_out, 1'b0);
    dimming_pwm_in <= 1'b1;
    for (n = 0; n < 8 && boost_gate_out !== 1'b1; n++) cyc(1);
    chk1(boost_gate_out, 1'b1);
  endtask : t_dim
  task automatic t_ctrl;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk1(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    wait_run(1'b0);
    cyc(700);
    chk1(boost_gate_out, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
    wait_run(1'b1);
  endtask : t_ctrl
  task automatic t_flags;
    headroom_low_in <= 1'b1;
    cyc(6);
    chk1(flyback_off_out, 1'b1);
    headroom_low_in <= 1'b0;
    cyc(6);
    chk1(flyback_off_out, 1'b0);
    input_supply_low_in <= 1'b1;
    headroom_low_in <= 1'b1;
    cyc(8);
    chk1(flyback_off_out | run, 1'b0);
    input_supply_low_in <= 1'b0;
    headroom_low_in <= 1'b0;
    cyc(20);
    chk1(run, 1'b1);
    output_over_voltage_in <= 1'b1;
    cyc(6);
    chk1(flyback_off_out & !run, 1'b1);
    output_over_voltage_in <= 1'b0;
    wait_run(1'b1);
  endtask : t_flags
  task automatic t_fault(input logic oc);
    if (oc) load_over_current_in <= 1'b1;
    else dimming_pwm_in <= 1'b0;
    cyc(80);
    chk1(load_gate_out | run, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd & 32'h5, oc ? 32'h1 : 32'h4);
    load_over_current_in <= 1'b0;
    dimming_pwm_in <= 1'b1;
    apb(1'b1, 12'h008, 32'hf);
    cyc(100);
    chk1(run, 1'b0);
    wait_run(1'b1);
  endtask : t_fault
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    cyc(60000);
    num_errors++;
    end_of_test;
  end
  initial begin
    cyc(2);
    rst_in <= 1'b0;
    t_start;
    t_pwm;
    t_dim;
    t_ctrl;
    t_flags;
    t_fault(1'b1);
    t_fault(1'b0);
    logic_supply_low_in <= 1'b1;
    wait_run(1'b0);
    end_of_test;
  end
endmodule : bsp_top_tb
`default_nettype wire

// [src/bsp_cfg.svh]
// timing, bus map and field constants for the boost switch pulse and fault logic
`ifndef BSP_CFG_SVH
`define BSP_CFG_SVH
`define BSP_CLK_HZ 125000000
`define BSP_SW_HZ 200000
`define BSP_SW_PERIOD_CYC (`BSP_CLK_HZ / `BSP_SW_HZ)
`define BSP_DUTY_CAP_CYC (`BSP_SW_PERIOD_CYC / 2)
`define BSP_BOOST_LEB_NS 80
`define BSP_BOOST_LEB_CYC ((`BSP_BOOST_LEB_NS * 125 + 999) / 1000)
`define BSP_LOAD_LEB_NS 600
`define BSP_LOAD_LEB_CYC ((`BSP_LOAD_LEB_NS * 125 + 999) / 1000)
`define BSP_CNT_W 10
`define BSP_ADDR_W 12
`define BSP_CTRL_ADDR 12'h000
`define BSP_STATUS_ADDR 12'h004
`define BSP_EVENT_ADDR 12'h008
`define BSP_CTRL_RST 32'h0000_0001
`define BSP_CTRL_EN_BIT 0
`define BSP_FLAG_W 9
`define BSP_F_LSL 0
`define BSP_F_ISL 1
`define BSP_F_HRL 2
`define BSP_F_OVV 3
`define BSP_F_LOC 4
`define BSP_F_TZ 5
`define BSP_F_TX 6
`define BSP_F_PK 7
`define BSP_F_DIM 8
`define BSP_EV_W 4
`define BSP_EV_OC 0
`define BSP_EV_OV 1
`define BSP_EV_STUCK 2
`define BSP_EV_SUPPLY 3
`endif

// [src/bsp_pkg.sv]
// state type for the boost switch pulse and fault logic
package bsp_pkg;
  typedef enum logic [2:0] {
    bsp_st_idle = 3'h0,
    bsp_st_run = 3'h1,
    bsp_st_fault = 3'h3,
    bsp_st_clear = 3'h2,
    bsp_st_retry = 3'h6
  } bsp_state_t;
endpackage : bsp_pkg

// [src/bsp_top.sv]
// boost gate pulse generator, fault state logic and apb control registers
// Summary of operation
// - end the boost gate pulse when the peak current flag is seen
// - also end the pulse at half the period, whichever comes first
// - oscillator runs at a fixed 200 kHz with constant period
// - gate pulses only while the boost converter is enabled
// - dimming rise restarts a fresh cycle, dimming fall stops the oscillator
// - peak flag ignored for a short blanking time at each pulse start
// - power-on reset initialises all state logic
// - both gates stay off during start-up and reset
// - logic supply low flag comes from a 4.4V/4.6V hysteresis comparator
// - input supply low flag blocks the first start of the boost
// - headroom low turns the flyback off, clearing it turns it back on
// - headroom shutdown applies only while the input supply is adequate
// - headroom low flag comes from a 0.47V/0.92V hysteresis comparator
// - overvoltage flag comes from a 1V/0.5V hysteresis comparator
// - load overcurrent turns the load switch off and enters fault
// - load overcurrent ignored for at least 600 ns after load turn-on
// - timer at zero flag means the timer has been reset
// - timer expired flag ends a timed interval
// - regular operation enables boost, load switch, amplifier and stuck timing
// - timer clear output discharges the timer capacitor
// - oc/ov fault holds while present, then retry delay, restart on expiry
// - dimming low for a ninth of retry delay is a fault with retry
// - input supply low in regular operation faults and restarts at once
// - flyback forced off on overvoltage and on headroom low in operation
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bsp_cfg.svh"

module bsp_top
  import bsp_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`BSP_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // comparator flags, asynchronous
  input wire logic logic_supply_low_in,
  input wire logic input_supply_low_in,
  input wire logic headroom_low_in,
  input wire logic output_over_voltage_in,
  input wire logic load_over_current_in,
  input wire logic timer_at_zero_in,
  input wire logic timer_expired_in,
  input wire logic peak_current_in,
  input wire logic dimming_pwm_in,
  // power stage controls
  output logic boost_gate_out,
  output logic load_gate_out,
  output logic regular_operation_en_out,
  output logic timer_clear_out,
  output logic flyback_off_out
);

  localparam logic [`BSP_CNT_W-1:0] PERIOD_C = `BSP_CNT_W'(`BSP_SW_PERIOD_CYC);
  localparam logic [`BSP_CNT_W-1:0] CAP_C = `BSP_CNT_W'(`BSP_DUTY_CAP_CYC);
  localparam logic [`BSP_CNT_W-1:0] BLEB_C = `BSP_CNT_W'(`BSP_BOOST_LEB_CYC);
  localparam logic [`BSP_CNT_W-1:0] LLEB_C = `BSP_CNT_W'(`BSP_LOAD_LEB_CYC);
  localparam logic [`BSP_CNT_W-1:0] ONE_C = `BSP_CNT_W'(1);

  // synchroniser; first stage feeds only the second
  logic [`BSP_FLAG_W-1:0] meta_q;
  logic [`BSP_FLAG_W-1:0] flag_q;
  logic [`BSP_FLAG_W-1:0] flag_raw;

  assign flag_raw = {dimming_pwm_in, peak_current_in, timer_expired_in,
    timer_at_zero_in, load_over_current_in, output_over_voltage_in, headroom_low_in,
    input_supply_low_in, logic_supply_low_in};

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_q <= '0;
      flag_q <= '0;
    end else begin
      meta_q <= flag_raw;
      flag_q <= meta_q;
    end
  end

  // hysteresis lives in the analog comparators; flags used as levels
  logic lsl_s;
  logic isl_s;
  logic hrl_s;
  logic ovv_s;
  logic loc_s;
  logic tz_s;
  logic tx_s;
  logic pk_s;
  logic dim_s;

  assign lsl_s = flag_q[`BSP_F_LSL];
  assign isl_s = flag_q[`BSP_F_ISL];
  assign hrl_s = flag_q[`BSP_F_HRL];
  assign ovv_s = flag_q[`BSP_F_OVV];
  assign loc_s = flag_q[`BSP_F_LOC];
  assign tz_s = flag_q[`BSP_F_TZ];
  assign tx_s = flag_q[`BSP_F_TX];
  assign pk_s = flag_q[`BSP_F_PK];
  assign dim_s = flag_q[`BSP_F_DIM];

  // registers
  bsp_state_t state_q, state_d;
  logic supply_cause_q;
  logic [31:0] ctrl_q;
  logic [`BSP_EV_W-1:0] event_q;
  logic run_q;
  logic [`BSP_CNT_W-1:0] cnt_q;
  logic gate_q;
  logic load_q;
  logic [`BSP_CNT_W-1:0] lleb_q;
  logic rop_q;
  logic tclr_q;
  logic fbo_q;

  logic enable;
  logic in_run;

  assign enable = ctrl_q[`BSP_CTRL_EN_BIT];
  assign in_run = state_q == bsp_st_run;

  // load switch overcurrent, blanked after each load turn-on
  // the drain discharge spike would otherwise trip a false fault
  logic lleb_done;
  logic oc_hit;
  logic ov_hit;
  logic stuck_hit;
  logic supply_hit;

  assign lleb_done = lleb_q >= LLEB_C;
  assign oc_hit = in_run && load_q && loc_s && lleb_done;
  assign ov_hit = in_run && ovv_s;
  assign stuck_hit = in_run && !dim_s && tx_s;
  assign supply_hit = in_run && isl_s;

  // fault state logic
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bsp_st_idle: begin
        if (enable && !isl_s && !ovv_s && !loc_s) begin
          state_d = bsp_st_run;
        end
      end
      bsp_st_run: begin
        if (supply_hit || oc_hit || ov_hit || stuck_hit) begin
          state_d = bsp_st_fault;
        end else if (!enable) begin
          state_d = bsp_st_idle;
        end
      end
      bsp_st_fault: begin
        if (supply_cause_q) begin
          if (!isl_s) begin
            state_d = bsp_st_idle;
          end
        end else if (!ovv_s && !loc_s) begin
          state_d = bsp_st_clear;
        end
      end
      bsp_st_clear: begin
        if (tz_s) begin
          state_d = bsp_st_retry;
        end
      end
      bsp_st_retry: begin
        if (tx_s) begin
          state_d = bsp_st_idle;
        end
      end
      default: state_d = bsp_st_idle;
    endcase
    if (lsl_s) begin
      state_d = bsp_st_idle;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= bsp_st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // remembers whether this fault may skip the retry delay
  logic fault_entry;

  assign fault_entry = in_run && (state_d == bsp_st_fault);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      supply_cause_q <= 1'b0;
    end else if (fault_entry) begin
      supply_cause_q <= supply_hit;
    end
  end

  // oscillator: counter wraps every period, restarts when run begins
  // short blanking keeps small duties reachable
  logic osc_run;
  logic cyc_start;
  logic [`BSP_CNT_W-1:0] cnt_d;
  logic cap_hit;
  logic peak_hit;
  logic gate_d;

  assign osc_run = in_run && dim_s && !lsl_s;
  assign cyc_start = osc_run && (!run_q || cnt_q == PERIOD_C - ONE_C);
  assign cnt_d = (!osc_run || cyc_start) ? '0 : cnt_q + ONE_C;
  assign cap_hit = cnt_d >= CAP_C;
  assign peak_hit = pk_s && cnt_q >= BLEB_C;
  assign gate_d = osc_run && (cyc_start || (gate_q && !cap_hit && !peak_hit));

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      run_q <= 1'b0;
      cnt_q <= '0;
      gate_q <= 1'b0;
    end else begin
      run_q <= osc_run;
      cnt_q <= cnt_d;
      gate_q <= gate_d;
    end
  end

  // load switch follows dimming while in regular operation
  logic load_d;
  logic [`BSP_CNT_W-1:0] lleb_d;

  assign load_d = in_run && dim_s && !oc_hit && !lsl_s;
  // blanking counter saturates so it never wraps back into blanking
  assign lleb_d = !load_q ? '0 : (lleb_done ? lleb_q : lleb_q + ONE_C);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      load_q <= 1'b0;
      lleb_q <= '0;
    end else begin
      load_q <= load_d;
      lleb_q <= lleb_d;
    end
  end

  // stage controls; timer held clear in operation while dimming is high
  logic rop_d;
  logic tclr_d;
  logic fbo_d;

  assign rop_d = state_d == bsp_st_run;
  assign tclr_d = (state_d == bsp_st_idle) || (state_d == bsp_st_fault) ||
    (state_d == bsp_st_clear) || (rop_d && dim_s);
  assign fbo_d = ovv_s || (hrl_s && !isl_s && in_run);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rop_q <= 1'b0;
      tclr_q <= 1'b1;
      fbo_q <= 1'b0;
    end else begin
      rop_q <= rop_d;
      tclr_q <= tclr_d;
      fbo_q <= fbo_d;
    end
  end

  // apb slave, zero wait states
  logic acc;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_ev;
  logic mapped;
  logic wr_ctrl;
  logic wr_ev;
  logic [`BSP_EV_W-1:0] ev_set;
  logic [`BSP_EV_W-1:0] ev_clr;
  logic [31:0] status_w;
  logic [31:0] rd_mux;
  logic rd_setup;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  assign acc = psel_in && penable_in;
  assign hit_ctrl = paddr_in == `BSP_CTRL_ADDR;
  assign hit_stat = paddr_in == `BSP_STATUS_ADDR;
  assign hit_ev = paddr_in == `BSP_EVENT_ADDR;
  assign mapped = hit_ctrl || hit_stat || hit_ev;
  assign wr_ctrl = acc && pwrite_in && hit_ctrl;
  assign wr_ev = acc && pwrite_in && hit_ev;
  assign ev_set = {supply_hit, stuck_hit, ov_hit, oc_hit};
  // set wins over a write-one-to-clear in the same cycle
  assign ev_clr = wr_ev ? pwdata_in[`BSP_EV_W-1:0] : '0;
  assign status_w = {16'h0000, 4'h0, load_q, gate_q, rop_q, tclr_q,
    1'b0, state_q, 1'b0, fbo_q, 1'b0, 1'b0} | {23'h000000, flag_q};
  assign rd_mux = hit_ctrl ? ctrl_q : hit_stat ? status_w :
    hit_ev ? {28'h0000000, event_q} : 32'h0000_0000;

  // read word captured in the setup cycle, so prdata leaves a flop
  // without a wait state; it is a snapshot of that cycle
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  assign rdata_d = rd_setup ? rd_mux : 32'h0000_0000;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl_q <= `BSP_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {31'h00000000, pwdata_in[`BSP_CTRL_EN_BIT]};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      event_q <= '0;
    end else begin
      event_q <= (event_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign pready_out = 1'b1;
  assign pslverr_out = acc && !mapped;
  assign prdata_out = rdata_q;

  assign boost_gate_out = gate_q;
  assign load_gate_out = load_q;
  assign regular_operation_en_out = rop_q;
  assign timer_clear_out = tclr_q;
  assign flyback_off_out = fbo_q;

endmodule : bsp_top
`default_nettype wire
